// ---- hdl/priority_reg_b_bank.sv ----
// module: ten priority level registers with a highest-level resolver
`timescale 1ns/10ps

module priority_reg_b_bank (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [3:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [15:0]  reg_rdata,
    input  wire logic [39:0]  src_req,
    output logic      [159:0] src_level,
    output logic              win_valid,
    output logic      [5:0]   win_src,
    output logic      [3:0]   win_level
);

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [15:0] prio_q [priority_reg_b_pkg::NUM_REGS];
    logic [15:0] rdata_d;
    logic        rd_hit;

    // index decode for reads; each register's write compares reg_addr against its own index
    function automatic logic addr_ok(input logic [3:0] a);
        return a <= priority_reg_b_pkg::IDX_PRIO_J;
    endfunction

    assign rd_hit  = addr_ok(reg_addr);
    assign rdata_d = rd_hit ? prio_q[reg_addr] : priority_reg_b_pkg::RD_UNMAPPED;

    // one register per index; all four fields written together
    genvar r;
    generate
        for (r = 0; r < priority_reg_b_pkg::NUM_REGS; r++) begin : g_reg
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    prio_q[r] <= priority_reg_b_pkg::PRIO_RST;
                end else if (reg_wr && reg_addr == 4'(r)) begin
                    prio_q[r] <= reg_wdata;
                end
            end
        end
    endgenerate

    property p_write_lands;
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && addr_ok(reg_addr)) |=> prio_q[$past(reg_addr)] == $past(reg_wdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write did not land");

    // unmapped write changes nothing
    // an address folded onto a real index would show up in the end registers
    property p_write_refused;
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && !addr_ok(reg_addr)) |=> $stable(prio_q[0]) && $stable(prio_q[9]);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("bad write stored");

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= priority_reg_b_pkg::RD_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    property p_read_hold;
        @(posedge ref_clk) disable iff (rst) !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");

    ////////////////////////////////////////////////////////////////////////
    // per-source levels and resolution

    logic [159:0] level_d;
    logic [39:0]  live;

    genvar s;
    generate
        for (s = 0; s < priority_reg_b_pkg::NUM_SRC; s++) begin : g_src
            assign level_d[s*4 +: 4] = prio_q[s/4][15-(s%4)*4 -: 4];
            assign live[s] = src_req[s] && (level_d[s*4 +: 4] != priority_reg_b_pkg::LEVEL_MASKED);
        end
    endgenerate

    property p_level_map;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> src_level[159:156] == $past(prio_q[9][3:0]);
    endproperty
    a_level_map: assert property (p_level_map) else $error("last field misplaced");

    property p_masked_src;
        @(posedge ref_clk) disable iff (rst)
        (src_req == 40'h00_0000_0001 && level_d[3:0] == priority_reg_b_pkg::LEVEL_MASKED) |=> !win_valid;
    endproperty
    a_masked_src: assert property (p_masked_src) else $error("masked source won");

    logic [3:0] best_lvl;
    logic [5:0] best_src;
    logic       best_ok;

    // unsigned compare, lower index wins ties
    always_comb begin
        best_lvl = priority_reg_b_pkg::LEVEL_MASKED;
        best_src = 6'h00;
        best_ok  = 1'b0;
        for (int i = priority_reg_b_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (live[i] && level_d[i*4 +: 4] >= best_lvl) begin
                best_lvl = level_d[i*4 +: 4];
                best_src = 6'(i);
                best_ok  = 1'b1;
            end
        end
    end

    // higher unsigned level wins
    // a signed compare would rank levels 8 to 15 below level 1
    property p_high_wins;
        @(posedge ref_clk) disable iff (rst)
        (src_req == 40'h00_0000_0104 && level_d[35:32] > level_d[11:8]
            && level_d[11:8] != priority_reg_b_pkg::LEVEL_MASKED) |=> win_valid && win_src == 6'h08;
    endproperty
    a_high_wins: assert property (p_high_wins) else $error("lower level won");

    property p_tie_low;
        @(posedge ref_clk) disable iff (rst)
        (live[3:0] == 4'h6 && src_req[39:4] == 36'h0_0000_0000
            && level_d[7:4] == level_d[11:8]) |=> win_src == 6'h01;
    endproperty
    a_tie_low: assert property (p_tie_low) else $error("tie went to higher index");

    // registered resolver outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_level <= '0;
            win_valid <= 1'b0;
            win_src   <= 6'h00;
            win_level <= priority_reg_b_pkg::LEVEL_MASKED;
        end else begin
            src_level <= level_d;
            win_valid <= best_ok;
            win_src   <= best_src;
            win_level <= best_lvl;
        end
    end

    property p_reset_out;
        @(posedge ref_clk) rst |=> !win_valid && src_level == '0
            && reg_rdata == priority_reg_b_pkg::RD_UNMAPPED;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("output not cleared");

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_reset_clear;
        @(posedge ref_clk) rst |=> (prio_q[0] == 16'h0000 && prio_q[9] == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left a field set");

    property p_write_read;
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && reg_addr == 4'h3) ##1 (reg_rd && reg_addr == 4'h3 && !reg_wr)
        |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_write_read: assert property (p_write_read) else $error("readback differs");

    property p_masked;
        @(posedge ref_clk) disable iff (rst) win_valid |-> win_level != 4'h0;
    endproperty
    a_masked: assert property (p_masked) else $error("level zero accepted");

    property p_win_level;
        @(posedge ref_clk) disable iff (rst)
        win_valid |-> win_level == src_level[win_src*4 +: 4];
    endproperty
    a_win_level: assert property (p_win_level) else $error("winner level wrong");

    // the whole request word is taken from last cycle, the index from this one
    property p_win_req;
        @(posedge ref_clk) disable iff (rst)
        win_valid |-> |($past(src_req) & (40'h00_0000_0001 << win_src));
    endproperty
    a_win_req: assert property (p_win_req) else $error("winner not requesting");

    property p_tie;
        @(posedge ref_clk) disable iff (rst)
        (live[0] && live[1] && level_d[3:0] == level_d[7:4] && level_d[3:0] == 4'hF)
        |=> win_src == 6'h00;
    endproperty
    a_tie: assert property (p_tie) else $error("tie not broken to lower index");

    property p_field_map;
        @(posedge ref_clk) disable iff (rst)
        (reg_wr && reg_addr == 4'h0) |=> ##1 src_level[3:0] == $past(reg_wdata[15:12], 2);
    endproperty
    a_field_map: assert property (p_field_map) else $error("top field not source 0");

    property p_unmapped;
        @(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr > 4'h9) |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

// ---- inc/priority_reg_b_pkg.sv ----
// package: register map, field layout and resolver constants of the priority bank
package priority_reg_b_pkg;
    localparam int          NUM_REGS     = 10;
    localparam int          REG_W        = 16;
    localparam int          FLD_W        = 4;
    localparam int          FLD_PER_REG  = 4;
    localparam int          NUM_SRC      = NUM_REGS * FLD_PER_REG;
    localparam int          ADDR_W       = 4;
    localparam int          SRC_W        = 6;
    // register indices (byte address is four times the index)
    localparam logic [3:0]  IDX_PRIO_A   = 4'h0;
    localparam logic [3:0]  IDX_PRIO_J   = 4'h9;
    localparam logic [15:0] PRIO_RST     = 16'h0000;
    localparam logic [3:0]  LEVEL_MASKED = 4'h0;
    localparam logic [15:0] RD_UNMAPPED  = 16'h0000;
endpackage

// ---- tb/priority_reg_b_bank_tb.sv ----
// testbench: register access, level outputs and winner selection of the priority bank
`timescale 1ns/10ps

module priority_reg_b_bank_tb;
    logic         ref_clk   = 1'b0;
    logic         rst       = 1'b1;
    logic [3:0]   reg_addr  = 4'h0;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic [15:0]  reg_rdata;
    logic [39:0]  src_req   = 40'h00_0000_0000;
    logic [159:0] src_level;
    logic         win_valid;
    logic [5:0]   win_src;
    logic [3:0]   win_level;
    int           n_mismatch = 0;
    int           checked    = 0;

    priority_reg_b_bank priority_reg_b_bank_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_req(src_req), .src_level(src_level), .win_valid(win_valid),
        .win_src(win_src), .win_level(win_level));

    // free-running clock, 50 ns period
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare, bus cycles and expected patterns
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    // read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    function automatic logic [15:0] pat(input int i);
        return 16'hFEDC - 16'(i) * 16'h1111;
    endfunction
    // drive requests, judge the winner one cycle later
    task automatic req(input logic [39:0] r, input logic v, input logic [5:0] s,
                       input logic [3:0] l);
        @(posedge ref_clk) src_req <= r;
        @(posedge ref_clk) #1;
        check({11'h000, win_valid, win_level}, {11'h000, v, l});
        if (v) check({10'h000, win_src}, {10'h000, s});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        logic [15:0] d;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), d);
            check(d, 16'h0000);
        end
        check(16'(|src_level) | 16'(win_valid), 16'h0000);
        $display("reset values done");
    endtask
    task automatic t_rw;
        logic [15:0] d;
        logic [15:0] p;
        for (int i = 0; i < 10; i++) wr(4'(i), pat(i));
        wr(4'hA, 16'hFFFF);
        for (int i = 0; i < 11; i++) begin
            rd(4'(i), d);
            check(d, (i < 10) ? pat(i) : 16'h0000);
        end
        for (int s = 0; s < 40; s++) begin
            p = pat(s / 4);
            check({12'h000, src_level[4*s +: 4]}, {12'h000, p[12 - 4 * (s % 4) +: 4]});
        end
        $display("register access done");
    endtask
    task automatic t_win;
        wr(4'h0, 16'h0550);
        req(40'h00_0000_000F, 1'b1, 6'h01, 4'h5);
        req(40'h00_0000_0001, 1'b0, 6'h00, 4'h0);
        wr(4'h1, 16'h5000);
        req(40'h00_0000_0014, 1'b1, 6'h02, 4'h5);
        req(40'h00_0000_0104, 1'b1, 6'h08, 4'hD);
        wr(4'h0, 16'hFF00);
        req(40'h00_0000_0003, 1'b1, 6'h00, 4'hF);
        $display("winner selection done");
    endtask
    // back-to-back strobes: write then read of one register, twice
    task automatic t_b2b;
        @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, 4'h3, 16'h1234};
        @(posedge ref_clk) {reg_wr, reg_rd} <= 2'h1;
        @(posedge ref_clk) {reg_wr, reg_rd, reg_wdata} <= {1'b1, 1'b0, 16'hABCD};
        #1 check(reg_rdata, 16'h1234);
        @(posedge ref_clk) {reg_wr, reg_rd} <= 2'h1;
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 check(reg_rdata, 16'hABCD);
        $display("back-to-back access done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_rw;
        t_win;
        t_b2b;
        // second reset in mid-run must clear the programmed levels again
        @(posedge ref_clk) rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        finish_test;
    end
endmodule
